// File: fbhm_cfg.svh
`ifndef FBHM_CFG_SVH
`define FBHM_CFG_SVH

// Table geometry
`define FBHM_NUM_BLOCKS 16
`define FBHM_BLK_W 4
`define FBHM_CNT_W 16
// Wear and health thresholds
`define FBHM_WEAR_LIMIT 16'h0010
`define FBHM_REFRESH_THR 8'h30
`define FBHM_RETIRE_THR 8'h40
// Correction strength: bits per unit and unit size in bytes
`define FBHM_ECC_BITS 8'h48
`define FBHM_ECC_UNIT_BYTES 1024
// AXI register byte offsets
`define FBHM_REG_CTRL 12'h000
`define FBHM_REG_STATUS 12'h004
`define FBHM_REG_STATIC 12'h008
`define FBHM_REG_COUNTS 12'h00C
`define FBHM_REG_WEARSEL 12'h010
`define FBHM_REG_WEARVAL 12'h014
`define FBHM_REG_BADMAP 12'h018
// Control bit positions
`define FBHM_CTRL_FREEZE 0
// AXI responses
`define FBHM_RESP_OKAY 2'b00
`define FBHM_RESP_SLVERR 2'b10

`endif

// File: fbhm_pkg.sv
package fbhm_pkg;

    // Flash operation request from the media side
    typedef struct packed {
        logic [1:0] op;
        logic [3:0] blk;
    } fbhm_req_t;

    // Flash operation codes
    typedef enum logic [1:0] {
        FBHM_OP_READ = 2'b00,
        FBHM_OP_PROG = 2'b01,
        FBHM_OP_ERASE = 2'b10,
        FBHM_OP_ALLOC = 2'b11
    } fbhm_op_t;

    // Maintenance sequencer states
    typedef enum logic [2:0] {
        FBHM_IDLE = 3'b000,
        FBHM_SWAP = 3'b001,
        FBHM_REFRESH = 3'b010,
        FBHM_RELOCATE = 3'b011,
        FBHM_RETIRE = 3'b100
    } fbhm_state_t;

    // Job issued to the flash sequencer
    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] src;
        logic [3:0] dst;
    } fbhm_job_t;

endpackage : fbhm_pkg

// File: fbhm_wear_cell.sv
`timescale 1ns/10ps
`include "fbhm_cfg.svh"
// One wear table entry: erase counter plus bad-block mark
module fbhm_wear_cell #(
    parameter int CNT_W = `FBHM_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic eraseHit,
    input wire logic retireHit,
    output logic [CNT_W-1:0] eraseCnt,
    output logic isBad
);
    // Counter saturates so an old block never looks fresh again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eraseCnt <= '0;
        end else if (eraseHit && (eraseCnt != {CNT_W{1'b1}})) begin
            eraseCnt <= eraseCnt + 1'b1;
        end
    end

    // Bad mark is sticky until reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isBad <= 1'b0;
        end else if (retireHit) begin
            isBad <= 1'b1;
        end
    end
endmodule : fbhm_wear_cell

// File: fbhm_health_mgr.sv
`timescale 1ns/10ps
`include "fbhm_cfg.svh"
// Operation
// - Count erases per block in wear table
// - Track static block in wear pointer
// - One spare pool across all chips
// - Worn spare block gets static data swapped
// - BCH corrects 72 bits per 1KB
// - Correction inline, host traffic unaffected
// - Refresh data when errors reach threshold
// - Relocate when errors exceed higher threshold
// - Mark relocated source bad, never allocate
// - Relocated data passes through correction
// - Freeze holds state, refuses host traffic
// - Freeze blocks new flash issue, program finishes
module fbhm_health_mgr import fbhm_pkg::*; #(
    parameter int NBLK = `FBHM_NUM_BLOCKS,
    parameter int CNT_W = `FBHM_CNT_W,
    parameter logic [CNT_W-1:0] WEAR_LIMIT = `FBHM_WEAR_LIMIT,
    parameter logic [7:0] REFRESH_THR = `FBHM_REFRESH_THR,
    parameter logic [7:0] RETIRE_THR = `FBHM_RETIRE_THR
) (
    input wire logic clk,
    input wire logic rst,
    // Media event stream
    input wire logic reqValid,
    output logic reqReady,
    input wire fbhm_req_t req,
    input wire logic [7:0] corrBits,
    input wire logic progBusy,
    // Host-side acceptance gate
    input wire logic hostReqIn,
    output logic hostAccept,
    // Power-fail warning
    input wire logic powerFail,
    // Maintenance job to the flash sequencer
    output logic jobValid,
    input wire logic jobReady,
    output fbhm_job_t job,
    output logic eccCorrectEn,
    output logic [3:0] allocBlk,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Retire threshold must sit above refresh threshold
    localparam bit THR_OK = (RETIRE_THR > REFRESH_THR);

    fbhm_state_t state_ff; // Maintenance state
    fbhm_job_t job_ff; // Pending job payload
    logic jobValid_ff; // Job offered downstream
    logic [CNT_W-1:0] eraseCnt [NBLK]; // Wear table counts
    logic [NBLK-1:0] badMap; // Retired blocks
    logic [NBLK-1:0] eraseHit; // One-hot erase strobe
    logic [NBLK-1:0] retireHit; // One-hot retire strobe
    logic [3:0] staticPtr_ff; // Wear pointer to static block
    logic [3:0] spareCur_ff; // Round-robin pool cursor
    logic [3:0] allocBlk_ff; // Last block handed out
    logic [3:0] healthyBlk; // Next free healthy block
    logic freezeSw_ff; // Software freeze
    logic [15:0] refreshCnt_ff; // Refresh events
    logic [15:0] retireCnt_ff; // Retire events
    logic [3:0] wearSel_ff; // Table entry selector
    logic frozen; // Combined freeze
    logic reqFire; // Event accepted
    logic awTaken_ff; // Write address held
    logic wTaken_ff; // Write data held
    logic [11:0] awAddr_ff; // Latched write address
    logic [31:0] wData_ff; // Latched write data
    logic [3:0] wStrb_ff; // Latched strobes

    assign frozen = powerFail | freezeSw_ff;
    // Refuse host traffic while frozen
    assign hostAccept = hostReqIn & ~frozen;
    // Events stall while frozen or busy with maintenance
    assign reqReady = ~frozen & (state_ff == FBHM_IDLE) & ~jobValid_ff;
    assign reqFire = reqValid & reqReady;
    // No new job handed out while frozen; running program is not touched
    assign jobValid = jobValid_ff & ~frozen & ~progBusy;
    assign job = job_ff;
    // Relocation and refresh data always go through correction
    assign eccCorrectEn = 1'b1;
    assign allocBlk = allocBlk_ff;

    // Per-block wear entries
    genvar g;
    generate
        for (g = 0; g < NBLK; g++) begin : gWear
            assign eraseHit[g] = reqFire && (req.op == FBHM_OP_ERASE) && (req.blk == g);
            fbhm_wear_cell #(.CNT_W(CNT_W)) uCell (
                .clk(clk),
                .rst(rst),
                .eraseHit(eraseHit[g]),
                .retireHit(retireHit[g]),
                .eraseCnt(eraseCnt[g]),
                .isBad(badMap[g])
            );
        end
    endgenerate

    // Search the single shared pool for a healthy block after the cursor
    always_comb begin
        healthyBlk = spareCur_ff;
        for (int i = NBLK - 1; i >= 1; i--) begin
            if (!badMap[4'(spareCur_ff + 4'(i))] && (4'(spareCur_ff + 4'(i)) != staticPtr_ff)) begin
                healthyBlk = 4'(spareCur_ff + 4'(i));
            end
        end
    end

    // Retire strobe is one-hot on the job source in the retire state
    always_comb begin
        retireHit = '0;
        if (state_ff == FBHM_RETIRE) begin
            retireHit[job_ff.src] = 1'b1;
        end
    end

    // Static pointer: block with the lowest erase count among healthy ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            staticPtr_ff <= 4'h0;
        end else if (!frozen) begin
            for (int i = 0; i < NBLK; i++) begin
                if (!badMap[i] && (eraseCnt[i] < eraseCnt[staticPtr_ff])) begin
                    staticPtr_ff <= 4'(i);
                end
            end
            if (badMap[staticPtr_ff]) begin
                staticPtr_ff <= healthyBlk;
            end
        end
    end

    // Maintenance sequencer; holds steady while frozen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= FBHM_IDLE;
            job_ff <= '0;
            jobValid_ff <= 1'b0;
            spareCur_ff <= 4'h0;
            allocBlk_ff <= 4'h0;
        end else if (!frozen) begin
            case (state_ff)
                FBHM_IDLE: begin
                    if (reqFire && req.op == FBHM_OP_ALLOC) begin
                        allocBlk_ff <= healthyBlk;
                        spareCur_ff <= healthyBlk;
                        if (eraseCnt[healthyBlk] > WEAR_LIMIT) begin
                            job_ff <= '{kind: 2'b00, src: staticPtr_ff, dst: healthyBlk};
                            jobValid_ff <= 1'b1;
                            state_ff <= FBHM_SWAP;
                        end
                    end else if (reqFire && req.op == FBHM_OP_READ) begin
                        if (THR_OK && corrBits > RETIRE_THR) begin
                            job_ff <= '{kind: 2'b10, src: req.blk, dst: healthyBlk};
                            jobValid_ff <= 1'b1;
                            spareCur_ff <= healthyBlk;
                            state_ff <= FBHM_RELOCATE;
                        end else if (corrBits >= REFRESH_THR) begin
                            job_ff <= '{kind: 2'b01, src: req.blk, dst: req.blk};
                            jobValid_ff <= 1'b1;
                            state_ff <= FBHM_REFRESH;
                        end
                    end
                end
                FBHM_SWAP, FBHM_REFRESH: begin
                    if (jobValid && jobReady) begin
                        jobValid_ff <= 1'b0;
                        state_ff <= FBHM_IDLE;
                    end
                end
                FBHM_RELOCATE: begin
                    if (jobValid && jobReady) begin
                        jobValid_ff <= 1'b0;
                        state_ff <= FBHM_RETIRE;
                    end
                end
                FBHM_RETIRE: begin
                    state_ff <= FBHM_IDLE;
                end
                default: begin
                    state_ff <= FBHM_IDLE;
                end
            endcase
        end
    end

    // Event counters for software; saturate rather than wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refreshCnt_ff <= 16'h0000;
            retireCnt_ff <= 16'h0000;
        end else begin
            if (state_ff == FBHM_REFRESH && jobValid && jobReady && refreshCnt_ff != 16'hFFFF) begin
                refreshCnt_ff <= refreshCnt_ff + 16'h0001;
            end
            if (state_ff == FBHM_RETIRE && !frozen && retireCnt_ff != 16'hFFFF) begin
                retireCnt_ff <= retireCnt_ff + 16'h0001;
            end
        end
    end

    // AXI write channel capture: address and data in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awTaken_ff <= 1'b0;
            wTaken_ff <= 1'b0;
            awAddr_ff <= 12'h000;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wTaken_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (awTaken_ff && wTaken_ff) begin
                awTaken_ff <= 1'b0;
                wTaken_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~awTaken_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~wTaken_ff & ~s_axi_bvalid;

    // Register writes and write response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FBHM_RESP_OKAY;
            freezeSw_ff <= 1'b0;
            wearSel_ff <= 4'h0;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (awTaken_ff && wTaken_ff) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `FBHM_RESP_OKAY;
                case (awAddr_ff[11:2])
                    10'(`FBHM_REG_CTRL >> 2): begin
                        if (wStrb_ff[0]) begin
                            freezeSw_ff <= wData_ff[`FBHM_CTRL_FREEZE];
                        end
                    end
                    10'(`FBHM_REG_WEARSEL >> 2): begin
                        if (wStrb_ff[0]) begin
                            wearSel_ff <= wData_ff[3:0];
                        end
                    end
                    10'(`FBHM_REG_STATUS >> 2), 10'(`FBHM_REG_STATIC >> 2),
                    10'(`FBHM_REG_COUNTS >> 2), 10'(`FBHM_REG_WEARVAL >> 2),
                    10'(`FBHM_REG_BADMAP >> 2): begin
                        s_axi_bresp <= `FBHM_RESP_OKAY; // Read-only, write ignored
                    end
                    default: begin
                        s_axi_bresp <= `FBHM_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    // Register reads, answered one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FBHM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FBHM_RESP_OKAY;
            case (s_axi_araddr[11:2])
                10'(`FBHM_REG_CTRL >> 2): s_axi_rdata <= {31'h0, freezeSw_ff};
                10'(`FBHM_REG_STATUS >> 2): s_axi_rdata <= {27'h0, powerFail, frozen, state_ff};
                10'(`FBHM_REG_STATIC >> 2): s_axi_rdata <= {24'h0, allocBlk_ff, staticPtr_ff};
                10'(`FBHM_REG_COUNTS >> 2): s_axi_rdata <= {retireCnt_ff, refreshCnt_ff};
                10'(`FBHM_REG_WEARSEL >> 2): s_axi_rdata <= {28'h0, wearSel_ff};
                10'(`FBHM_REG_WEARVAL >> 2): s_axi_rdata <= 32'(eraseCnt[wearSel_ff]);
                10'(`FBHM_REG_BADMAP >> 2): s_axi_rdata <= 32'(badMap);
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `FBHM_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : fbhm_health_mgr

// File: fbhm_health_mgr_monitor.sv
`timescale 1ns/10ps
`include "fbhm_cfg.svh"
// Watches media events, job issue and freeze gating at the top ports
module fbhm_health_mon import fbhm_pkg::*; #(
    parameter logic [7:0] REFRESH_THR = `FBHM_REFRESH_THR,
    parameter logic [7:0] RETIRE_THR = `FBHM_RETIRE_THR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire fbhm_req_t req,
    input wire logic [7:0] corrBits,
    input wire logic progBusy,
    input wire logic hostAccept,
    input wire logic powerFail,
    input wire logic jobValid,
    input wire logic jobReady,
    input wire fbhm_job_t job,
    input wire logic eccCorrectEn,
    input wire logic [3:0] allocBlk
);
    wire logic fire = reqValid && reqReady; // Event taken on this edge
    wire logic isRead = req.op == FBHM_OP_READ; // Read event offered
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    freeze_gate_a:
    assert property (powerFail |-> !hostAccept && !reqReady) else $error("traffic while frozen");
    job_hold_a:
    assert property (jobValid && !jobReady |=> jobValid && $stable(job)) else $error("job dropped");
    issue_gate_a:
    assert property ($rose(jobValid) |-> !progBusy && !powerFail) else $error("job while blocked");
    relocate_job_a:
    assert property (fire && isRead && corrBits > RETIRE_THR ##1 !progBusy && !powerFail
        |-> jobValid && job.kind == 2'h2 && job.src == $past(req.blk)) else $error("no relocate");
    refresh_job_a:
    assert property (fire && isRead && corrBits >= REFRESH_THR && corrBits <= RETIRE_THR
        ##1 !progBusy && !powerFail |-> jobValid && job.kind == 2'h1) else $error("no refresh");
    quiet_read_a:
    assert property (fire && isRead && corrBits < REFRESH_THR |=> !jobValid) else $error("extra job");
    alloc_track_a:
    assert property (!(fire && req.op == FBHM_OP_ALLOC) |=> $stable(allocBlk))
        else $error("alloc block moved");
    swap_dst_a:
    assert property ($rose(jobValid) && job.kind == 2'h0 |-> job.dst == allocBlk)
        else $error("swap target wrong");
    ecc_inline_a:
    assert property (eccCorrectEn) else $error("correction off");
endmodule : fbhm_health_mon
bind fbhm_health_mgr fbhm_health_mon #(.REFRESH_THR(REFRESH_THR), .RETIRE_THR(RETIRE_THR)) i_mon (.*);

// File: fbhm_flash_model.sv
`timescale 1ns/10ps
// Flash sequencer stand-in: takes maintenance jobs after a set lag
module fbhm_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic jobValid,
    input wire logic eccCorrectEn,
    input wire logic [3:0] lag,
    output logic jobReady,
    output logic copyDirty_ff
);
    logic [3:0] waitCnt_ff; // Cycles the current job has been offered
    // Lag zero answers at once; larger lags model a busy array
    assign jobReady = jobValid && (waitCnt_ff >= lag);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_ff <= 4'h0;
        end else if (!jobValid || jobReady) begin
            waitCnt_ff <= 4'h0;
        end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
        end
    end
    // Sticky: a copy was taken while correction was off, so bad bits would land
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            copyDirty_ff <= 1'h0;
        end else if (jobReady && !eccCorrectEn) begin
            copyDirty_ff <= 1'h1;
        end
    end
endmodule : fbhm_flash_model

// File: tb.sv
`timescale 1ns/10ps
`include "fbhm_cfg.svh"
// Self-checking bench: media events, job issue, freeze and registers
module tb import fbhm_pkg::*; ();
    logic clk = 1'h0, rst = 1'h1, reqValid = 1'h0, progBusy = 1'h0, hostReqIn = 1'h0;
    logic powerFail = 1'h0, reqReady, hostAccept, jobValid, jobReady, eccCorrectEn, copyDirty_ff;
    fbhm_req_t req = '0;
    fbhm_job_t job;
    logic [7:0] corrBits = 8'h00;
    logic [3:0] allocBlk, lag = 4'h0, s_axi_wstrb = 4'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errTotal = 0, checked = 0;
    always #10 clk = ~clk; // 50 MHz
    fbhm_health_mgr i_dut (.*);
    fbhm_flash_model i_flash (.*);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // A wait that ran out counts against the run
    task automatic hang;
        errTotal++;
        complete_run();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // Offer one media event and hold it until taken
    task automatic ev(input logic [1:0] op, input logic [3:0] blk, input logic [7:0] bits);
        @(posedge clk);
        reqValid <= 1'h1;
        req <= {op, blk};
        corrBits <= bits;
        for (int n = 0; n <= 60; n++) begin
            if (n == 60) hang();
            @(negedge clk);
            if (reqReady === 1'h1) break;
        end
        @(posedge clk);
        reqValid <= 1'h0;
    endtask : ev
    // Wait for a job handshake, check kind and source or target block
    task automatic jobwait(input logic [1:0] kind, input logic [3:0] blk, input logic dst);
        for (int n = 0; n <= 60; n++) begin
            if (n == 60) hang();
            @(negedge clk);
            if (jobValid === 1'h1 && jobReady === 1'h1) break;
        end
        chk({30'h0, job.kind}, {30'h0, kind});
        chk({28'h0, dst ? job.dst : job.src}, {28'h0, blk});
        @(posedge clk);
    endtask : jobwait
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] rsp;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n <= 60; n++) begin
            if (n == 60) hang();
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) begin
                s_axi_bready <= 1'h0;
                break;
            end
        end
        chk({30'h0, rsp}, {30'h0, er});
    endtask : wr
    // Read a word and compare the masked data and the response
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
            input logic [1:0] er);
        logic ar, r;
        logic [31:0] d;
        logic [1:0] rsp;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n <= 60; n++) begin
            if (n == 60) hang();
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (r) begin
                s_axi_rready <= 1'h0;
                break;
            end
        end
        chk(d & m, e);
        chk({30'h0, rsp}, {30'h0, er});
    endtask : rdc
    // Reset values, unmapped place, per-block erase counts
    task automatic t_erase;
        rdc(`FBHM_REG_CTRL, 32'hFFFFFFFF, 32'h0, `FBHM_RESP_OKAY);
        wr(12'h100, 32'h1, `FBHM_RESP_SLVERR);
        rdc(12'h100, 32'hFFFFFFFF, 32'h0, `FBHM_RESP_SLVERR);
        repeat (2) ev(FBHM_OP_ERASE, 4'h3, 8'h00);
        wr(`FBHM_REG_WEARSEL, 32'h3, `FBHM_RESP_OKAY);
        rdc(`FBHM_REG_WEARVAL, 32'hFFFF, 32'h2, `FBHM_RESP_OKAY);
        wr(`FBHM_REG_WEARSEL, 32'h4, `FBHM_RESP_OKAY);
        rdc(`FBHM_REG_WEARVAL, 32'hFFFF, 32'h0, `FBHM_RESP_OKAY);
        $display("done erase");
    endtask : t_erase
    // Pool hands out the next healthy block after its cursor, never the static one:
    // block 1 at the limit gives no swap, block 2 one above it does; slow partner
    task automatic t_swap;
        lag <= 4'h3;
        repeat (16) ev(FBHM_OP_ERASE, 4'h1, 8'h00);
        ev(FBHM_OP_ALLOC, 4'h0, 8'h00);
        repeat (3) @(negedge clk);
        chk1(jobValid, 1'h0);
        chk({28'h0, allocBlk}, 32'h1);
        repeat (17) ev(FBHM_OP_ERASE, 4'h2, 8'h00);
        ev(FBHM_OP_ALLOC, 4'h0, 8'h00);
        jobwait(2'h0, 4'h2, 1'h1);
        rdc(`FBHM_REG_STATIC, 32'hFF, 32'h20, `FBHM_RESP_OKAY);
        $display("done swap");
    endtask : t_swap
    // Threshold edges for refresh and relocation, then the bad mark
    task automatic t_health;
        lag <= 4'h0;
        ev(FBHM_OP_READ, 4'h2, 8'h2F);
        repeat (3) @(negedge clk);
        chk1(jobValid, 1'h0);
        ev(FBHM_OP_READ, 4'h2, 8'h30);
        jobwait(2'h1, 4'h2, 1'h0);
        ev(FBHM_OP_READ, 4'h4, 8'h40);
        jobwait(2'h1, 4'h4, 1'h0);
        ev(FBHM_OP_READ, 4'h7, 8'h41);
        jobwait(2'h2, 4'h7, 1'h0);
        rdc(`FBHM_REG_BADMAP, 32'hFFFF, 32'h80, `FBHM_RESP_OKAY);
        rdc(`FBHM_REG_COUNTS, 32'hFFFFFFFF, 32'h00010002, `FBHM_RESP_OKAY);
        $display("done health");
    endtask : t_health
    // A running program holds back job issue
    task automatic t_busy;
        progBusy <= 1'h1;
        ev(FBHM_OP_READ, 4'h9, 8'h41);
        repeat (4) @(negedge clk);
        chk1(jobValid, 1'h0);
        @(posedge clk);
        progBusy <= 1'h0;
        jobwait(2'h2, 4'h9, 1'h0);
        rdc(`FBHM_REG_BADMAP, 32'hFFFF, 32'h280, `FBHM_RESP_OKAY);
        chk1(copyDirty_ff, 1'h0);
        chk1(eccCorrectEn, 1'h1);
        $display("done busy");
    endtask : t_busy
    // Power-fail and software freeze both shut the host gate
    task automatic t_freeze;
        hostReqIn <= 1'h1;
        @(negedge clk);
        chk1(hostAccept, 1'h1);
        @(posedge clk);
        powerFail <= 1'h1;
        @(negedge clk);
        chk1(hostAccept, 1'h0);
        chk1(reqReady, 1'h0);
        @(posedge clk);
        powerFail <= 1'h0;
        wr(`FBHM_REG_CTRL, 32'h1, `FBHM_RESP_OKAY);
        @(negedge clk);
        chk1(hostAccept, 1'h0);
        rdc(`FBHM_REG_STATUS, 32'h8, 32'h8, `FBHM_RESP_OKAY);
        wr(`FBHM_REG_CTRL, 32'h0, `FBHM_RESP_OKAY);
        @(negedge clk);
        chk1(hostAccept, 1'h1);
        @(posedge clk);
        hostReqIn <= 1'h0; // Host lets go between access cycles
        @(negedge clk);
        chk1(hostAccept, 1'h0);
        $display("done freeze");
    endtask : t_freeze
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_erase();
        t_swap();
        t_health();
        t_busy();
        t_freeze();
        complete_run();
    end
endmodule : tb
